// ### include/pmtf_params.svh
`ifndef PMTF_PARAMS_SVH
`define PMTF_PARAMS_SVH
// ****************************************
// Command codes
// ****************************************
`define PMTF_CMD_CLEAR     8'h03
`define PMTF_CMD_STORE     8'h15
`define PMTF_CMD_TMAX_RESP 8'h63
`define PMTF_CMD_TOFF_DLY  8'h64
`define PMTF_CMD_TURN_OFF_FALL_MS 8'h65
`define PMTF_CMD_STAT_BYTE 8'h78
`define PMTF_CMD_STAT_WORD 8'h79
// ****************************************
// Reset values, limits and field codes
// ****************************************
`define PMTF_ACT_RST       8'h80
`define PMTF_DLY_RST       16'h0000
`define PMTF_FALL_RST      16'h0005
`define PMTF_DLY_MAX       16'h000A
`define PMTF_FALL_MAX      16'h0014
`define PMTF_RESP_IGNORE   2'h0
`define PMTF_RESP_SHUT     2'h2
`define PMTF_RETRY_LATCH   3'h0
`define PMTF_RETRY_HICCUP  3'h7
// ****************************************
// Timing
// ****************************************
`define PMTF_CLK_NS        8
`define PMTF_MS_NS         1000000
`define PMTF_MS_CYCLES     (`PMTF_MS_NS / `PMTF_CLK_NS)
`define PMTF_HICCUP_MS     10'd1000
`endif

// ### include/pmtf_pkg.sv
package pmtf_pkg;
  typedef enum logic [2:0] {ST_OFF, ST_START, ST_RUN, ST_TDLY, ST_TFALL, ST_LATCH, ST_HIC} pmtf_st_t;
  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retry;
    logic [2:0] dly;
  } pmtf_act_t;
  typedef struct packed {
    logic vout_ovp, vout_uv, ioc_peak, ioc_avg, temp_flt, vin_ov, vin_off;
    logic sw_flt, boot_uv, pgood_flt, pec_err, out_valid, uv_reached, en_pin, nvm_busy;
    logic [7:0] vendor;
  } pmtf_pins_t;
  typedef struct packed {
    logic        wr;
    logic [7:0]  code;
    logic [15:0] data;
  } pmtf_req_t;
  typedef struct packed {
    logic        busy, tgl, a1, a2, a3, done;
    pmtf_req_t   req;
    logic [15:0] rdata;
  } pmtf_link_t;
  typedef struct packed {
    pmtf_st_t    st;
    logic [16:0] ms_cnt;
    logic [9:0]  tcnt;
    pmtf_act_t   act;
    logic [15:0] tdly, tfall;
    logic        inval, badcmd, tonmax;
    pmtf_pins_t  s1, s2;
    logic        rq1, rq2, rq3, ack;
    logic [15:0] rdata;
    logic        nvm_st, sw_on, vcmd_on, alert_n;
  } pmtf_core_t;
endpackage

// ### core/pmtf_top.sv
`timescale 1ns/1ps
`include "pmtf_params.svh"
// Operation
// - Timeout fault action resets to latch-off code 80h.
// - Timeout fault flag is sticky; only clear-faults clears it.
// - Response 00 keeps regulating through a timeout fault.
// - Response 10 disables output, then follows the retry field.
// - Retry 000 keeps output off until faults are cleared.
// - Retry 111 restarts every 1 s until off, unpowered or other fault.
// - Unsupported action encodings raise invalid-data fault.
// - Turn-off delay 0..10 ms, stop to end of energy transfer, resets 0.
// - Delay exponent reads zero; nonzero exponent or mantissa 10:4 is invalid.
// - Fall time 1..20 ms after delay until output commanded zero, resets 5.
// - Fall word: nonzero exponent, mantissa 10:5 or zero ms is invalid.
// - Timing words are 5-bit exponent over 11-bit mantissa in ms.
// - Store-all command copies these settings to nonvolatile storage.
// - Summary bit 7 shows nonvolatile memory access in progress.
// - Summary bits 6,5,4,2,1 report off, OV, peak OC, temp, comms.
// - Summary bit 0 flags faults outside the other bits, except the timeout fault.
// - Status word low byte is the summary byte itself.
// - Upper byte bits 7..4 summarise vout, iout, input, vendor faults.
// - Upper bit 3 is low while output valid, high otherwise.
// - Timeout fault sets vout summary, timeout bit and host alert.
// - Timeout fault when output misses UV threshold within max start time.
module pmtf_top
  import pmtf_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `PMTF_MS_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        link_clk_in,
  input  wire logic        link_wr_in,
  input  wire logic        link_rd_in,
  input  wire logic [7:0]  link_code_in,
  input  wire logic [15:0] link_wdata_in,
  input  wire pmtf_pins_t  pins_in,
  input  wire logic        op_on_in,
  input  wire logic [9:0]  ton_max_ms_in,
  output logic             link_busy_out,
  output logic             link_done_out,
  output logic [15:0]      link_rdata_out,
  output logic             host_alert_n_out,
  output logic             switching_on_out,
  output logic             vout_on_out,
  output logic             nvm_store_out,
  output logic [39:0]      nvm_image_out
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic act_ok(input logic [7:0] v);
    pmtf_act_t a;
    a = v;
    return (a.resp == `PMTF_RESP_IGNORE || a.resp == `PMTF_RESP_SHUT) &&
           (a.retry == `PMTF_RETRY_LATCH || a.retry == `PMTF_RETRY_HICCUP) &&
           a.dly == 3'h0;
  endfunction

  // Zero limit ends at once; otherwise ends on the tick that reaches it
  function automatic logic tdone(input logic tick, input logic [9:0] cnt, input logic [9:0] lim);
    return lim == 10'h000 || (tick && (cnt + 10'h001) >= lim);
  endfunction

  localparam pmtf_core_t CORE_RST = '{st: ST_OFF, act: `PMTF_ACT_RST, tdly: `PMTF_DLY_RST,
                                      tfall: `PMTF_FALL_RST, alert_n: 1'b1, default: '0};

  pmtf_core_t cq, cd;
  pmtf_link_t lq, ld;
  logic       tick;
  logic       run;
  logic       other;
  logic [7:0] sbyte;
  logic [7:0] ubyte;

  // ****************************************
  // Status composition
  // ****************************************
  assign other = cq.s2.vout_ovp | cq.s2.ioc_peak | cq.s2.temp_flt | cq.s2.vin_ov |
                 cq.s2.sw_flt | cq.s2.boot_uv;
  assign sbyte = {cq.s2.nvm_busy,
                  ~cq.vcmd_on, cq.s2.vout_ovp, cq.s2.ioc_peak, 1'b0, cq.s2.temp_flt,
                  cq.inval | cq.badcmd | cq.s2.pec_err,
                  cq.s2.vin_ov | cq.s2.vin_off | cq.s2.ioc_avg | cq.s2.sw_flt | cq.s2.boot_uv |
                  cq.s2.pgood_flt | cq.s2.vout_uv | (|cq.s2.vendor[7:1])};
  assign ubyte = {cq.s2.vout_ovp | cq.s2.vout_uv | cq.tonmax,
                  cq.s2.ioc_peak | cq.s2.ioc_avg,
                  cq.s2.vin_ov | cq.s2.vin_off,
                  |cq.s2.vendor[7:1],
                  ~cq.s2.out_valid,
                  3'h0};

  // ****************************************
  // Core domain
  // ****************************************
  always_comb begin
    cd = cq;
    cd.s1 = pins_in;
    cd.s2 = cq.s1;
    cd.rq1 = lq.tgl;
    cd.rq2 = cq.rq1;
    cd.rq3 = cq.rq2;
    cd.nvm_st = 1'b0;
    tick = cq.ms_cnt == 17'(MS_CYCLES - 1);
    cd.ms_cnt = tick ? 17'h00000 : cq.ms_cnt + 17'h00001;
    if (tick) begin
      cd.tcnt = cq.tcnt + 10'h001;
    end
    if (cq.rq2 ^ cq.rq3) begin
      // Request words held stable by the link side until the ack returns
      cd.ack = ~cq.ack;
      cd.rdata = 16'h0000;
      case (lq.req.code)
        `PMTF_CMD_TMAX_RESP: begin
          if (!lq.req.wr) begin
            cd.rdata = {8'h00, cq.act};
          end else if (act_ok(lq.req.data[7:0])) begin
            cd.act = lq.req.data[7:0];
          end else begin
            cd.inval = 1'b1;
          end
        end
        `PMTF_CMD_TOFF_DLY: begin
          if (!lq.req.wr) begin
            cd.rdata = cq.tdly;
          end else if (lq.req.data[15:4] == 12'h000 && lq.req.data <= `PMTF_DLY_MAX) begin
            cd.tdly = lq.req.data;
          end else begin
            cd.inval = 1'b1;
          end
        end
        `PMTF_CMD_TURN_OFF_FALL_MS: begin
          if (!lq.req.wr) begin
            cd.rdata = cq.tfall;
          end else if (lq.req.data[15:5] == 11'h000 && lq.req.data != 16'h0000 &&
                       lq.req.data <= `PMTF_FALL_MAX) begin
            cd.tfall = lq.req.data;
          end else begin
            cd.inval = 1'b1;
          end
        end
        `PMTF_CMD_STAT_BYTE: begin
          if (lq.req.wr) begin
            cd.badcmd = 1'b1;
          end else begin
            cd.rdata = {8'h00, sbyte};
          end
        end
        `PMTF_CMD_STAT_WORD: begin
          if (lq.req.wr) begin
            cd.badcmd = 1'b1;
          end else begin
            cd.rdata = {ubyte, sbyte};
          end
        end
        `PMTF_CMD_STORE: begin
          cd.nvm_st = lq.req.wr;
          cd.badcmd = ~lq.req.wr;
        end
        `PMTF_CMD_CLEAR: begin
          cd.inval = 1'b0;
          cd.badcmd = 1'b0;
          cd.tonmax = 1'b0;
        end
        default: begin
          cd.badcmd = 1'b1;
        end
      endcase
    end
    run = cq.s2.en_pin & op_on_in;
    case (cq.st)
      ST_OFF: begin
        if (run) begin
          cd.st = ST_START;
        end
      end
      ST_START: begin
        if (!run) begin
          cd.st = ST_TDLY;
        end else if (cq.s2.uv_reached) begin
          cd.st = ST_RUN;
        end else if (tdone(tick, cq.tcnt, ton_max_ms_in)) begin
          // Set after any clear above, so a coinciding clear loses
          cd.tonmax = 1'b1;
          if (cq.act.resp == `PMTF_RESP_IGNORE) begin
            cd.st = ST_RUN;
          end else if (cq.act.retry == `PMTF_RETRY_HICCUP) begin
            cd.st = ST_HIC;
          end else begin
            cd.st = ST_LATCH;
          end
        end
      end
      ST_RUN: begin
        if (!run) begin
          cd.st = ST_TDLY;
        end
      end
      ST_TDLY: begin
        if (tdone(tick, cq.tcnt, cq.tdly[9:0])) begin
          cd.st = ST_TFALL;
        end
      end
      ST_TFALL: begin
        if (tdone(tick, cq.tcnt, cq.tfall[9:0])) begin
          cd.st = ST_OFF;
        end
      end
      ST_LATCH: begin
        if (!cd.tonmax) begin
          cd.st = ST_OFF;
        end
      end
      ST_HIC: begin
        if (!run) begin
          cd.st = ST_OFF;
        end else if (other) begin
          cd.st = ST_LATCH;
        end else if (tdone(tick, cq.tcnt, `PMTF_HICCUP_MS)) begin
          cd.st = ST_START;
        end
      end
      default: begin
        cd.st = ST_OFF;
      end
    endcase
    // Each timed state counts whole milliseconds from its own entry
    if (cd.st != cq.st) begin
      cd.ms_cnt = 17'h00000;
      cd.tcnt = 10'h000;
    end
    cd.sw_on = cd.st == ST_START || cd.st == ST_RUN || cd.st == ST_TDLY;
    cd.vcmd_on = cd.sw_on || cd.st == ST_TFALL;
    cd.alert_n = ~(cd.tonmax | cd.inval | cd.badcmd | cq.s2.pec_err);
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cq <= CORE_RST;
    end else begin
      cq <= cd;
    end
  end

  // ****************************************
  // Link domain
  // ****************************************
  always_comb begin
    ld = lq;
    ld.a1 = cq.ack;
    ld.a2 = lq.a1;
    ld.a3 = lq.a2;
    ld.done = 1'b0;
    if (lq.busy && (lq.a2 ^ lq.a3)) begin
      ld.busy = 1'b0;
      ld.done = 1'b1;
      ld.rdata = cq.rdata;
    end else if (!lq.busy && (link_wr_in || link_rd_in)) begin
      // Requests while busy are dropped; the host waits for done
      ld.busy = 1'b1;
      ld.tgl = ~lq.tgl;
      ld.req = '{wr: link_wr_in, code: link_code_in, data: link_wdata_in};
    end
  end

  always_ff @(posedge link_clk_in or posedge rst_in) begin
    if (rst_in) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign link_busy_out    = lq.busy;
  assign link_done_out    = lq.done;
  assign link_rdata_out   = lq.rdata;
  assign host_alert_n_out = cq.alert_n;
  assign switching_on_out = cq.sw_on;
  assign vout_on_out      = cq.vcmd_on;
  assign nvm_store_out    = cq.nvm_st;
  assign nvm_image_out    = {cq.act, cq.tdly, cq.tfall};

  // ****************************************
  // Checks
  // ****************************************
  a_act_legal: assert property (@(posedge clk_in) disable iff (rst_in) act_ok(cq.act))
    else $error("illegal timeout action stored");
  a_flag_sticky: assert property (@(posedge clk_in) disable iff (rst_in)
    cq.tonmax && !((cq.rq2 ^ cq.rq3) && lq.req.code == `PMTF_CMD_CLEAR) |=> cq.tonmax)
    else $error("timeout flag dropped without clear");
  a_ignore_runs: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(cq.tonmax) && $past(cq.act.resp) == `PMTF_RESP_IGNORE |-> cq.sw_on && cq.st == ST_RUN)
    else $error("ignore response interrupted output");
  a_latch_off: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(cq.tonmax) && $past(cq.act) == `PMTF_ACT_RST |-> !cq.sw_on ##1 !cq.sw_on)
    else $error("latch-off left output on");
  a_hiccup_time: assert property (@(posedge clk_in) disable iff (rst_in)
    cq.st == ST_START && $past(cq.st) == ST_HIC |-> $past(cq.tcnt) == `PMTF_HICCUP_MS - 10'h001)
    else $error("hiccup restart not after 1 s");
  a_dly_range: assert property (@(posedge clk_in) disable iff (rst_in)
    cq.tdly[15:4] == 12'h000 && cq.tdly <= `PMTF_DLY_MAX)
    else $error("turn-off delay out of range");
  a_fall_range: assert property (@(posedge clk_in) disable iff (rst_in)
    cq.tfall[15:5] == 11'h000 && cq.tfall != 16'h0000 && cq.tfall <= `PMTF_FALL_MAX)
    else $error("turn-off fall out of range");
  a_busy_bit: assert property (@(posedge clk_in) disable iff (rst_in)
    (cq.rq2 ^ cq.rq3) && !lq.req.wr && lq.req.code == `PMTF_CMD_STAT_BYTE |=>
    cq.rdata[7] == $past(cq.s2.nvm_busy) && cq.rdata[15:8] == 8'h00)
    else $error("busy bit wrong");
  a_word_low: assert property (@(posedge clk_in) disable iff (rst_in)
    (cq.rq2 ^ cq.rq3) && !lq.req.wr && lq.req.code == `PMTF_CMD_STAT_WORD |=>
    cq.rdata[7:0] == $past(sbyte) && cq.rdata[11] == !$past(cq.s2.out_valid))
    else $error("status word mismatch");
  a_unsup_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    sbyte[3] == 1'b0 && ubyte[2:0] == 3'h0)
    else $error("unsupported bit set");
  a_alert_fault: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(cq.tonmax) |-> !host_alert_n_out && ubyte[7])
    else $error("timeout without alert");
  a_link_done: assert property (@(posedge link_clk_in) disable iff (rst_in)
    $rose(lq.busy) |-> ##[2:40] lq.done)
    else $error("link request never answered");
  a_rdata_hold: assert property (@(posedge link_clk_in) disable iff (rst_in)
    !lq.done |=> lq.done || lq.rdata == $past(lq.rdata))
    else $error("read data changed without done");

  // ****************************************
  // Sequencing and data-path checks
  // ****************************************
  // Output commands are decoded from the state alone; ST_OFF, ST_LATCH and ST_HIC all drive both low
  a_latch_hold: assert property (@(posedge clk_in) disable iff (rst_in)
    cq.st == ST_LATCH |-> !cq.sw_on && !cq.vcmd_on)
    else $error("latched state left output on");
  a_hiccup_off: assert property (@(posedge clk_in) disable iff (rst_in)
    cq.st == ST_HIC |-> !cq.sw_on && !cq.vcmd_on)
    else $error("output on during hiccup wait");
  a_hiccup_stop: assert property (@(posedge clk_in) disable iff (rst_in)
    cq.st == ST_HIC && !(cq.s2.en_pin && op_on_in) |=> cq.st == ST_OFF)
    else $error("hiccup retry not stopped by off command");
  a_ignore_keep: assert property (@(posedge clk_in) disable iff (rst_in)
    cq.st == ST_RUN && cq.tonmax && cq.s2.en_pin && op_on_in |=> cq.sw_on)
    else $error("regulation interrupted after ignored timeout");
  a_delay_on: assert property (@(posedge clk_in) disable iff (rst_in)
    cq.st == ST_TDLY |-> cq.sw_on && cq.vcmd_on)
    else $error("energy transfer stopped during turn-off delay");
  a_fall_on: assert property (@(posedge clk_in) disable iff (rst_in)
    cq.st == ST_TFALL |-> !cq.sw_on && cq.vcmd_on)
    else $error("output command wrong during fall time");
  a_store_once: assert property (@(posedge clk_in) disable iff (rst_in)
    nvm_store_out |=> !nvm_store_out)
    else $error("store request longer than one cycle");
  a_tmo_cause: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(cq.tonmax) |-> $past(cq.st) == ST_START && !$past(cq.s2.uv_reached))
    else $error("timeout flag without failed start");
  a_tmo_alert: assert property (@(posedge clk_in) disable iff (rst_in)
    cq.tonmax |-> !host_alert_n_out)
    else $error("timeout flag without alert");
  a_dly_exp: assert property (@(posedge clk_in) disable iff (rst_in)
    (cq.rq2 ^ cq.rq3) && !lq.req.wr && lq.req.code == `PMTF_CMD_TOFF_DLY |=> cq.rdata[15:11] == 5'h00)
    else $error("delay exponent read nonzero");
  a_act_reject: assert property (@(posedge clk_in) disable iff (rst_in)
    (cq.rq2 ^ cq.rq3) && lq.req.wr && lq.req.code == `PMTF_CMD_TMAX_RESP && !act_ok(lq.req.data[7:0]) |=>
    cq.inval && cq.act == $past(cq.act))
    else $error("unsupported action accepted");
  a_fall_zero: assert property (@(posedge clk_in) disable iff (rst_in)
    (cq.rq2 ^ cq.rq3) && lq.req.wr && lq.req.code == `PMTF_CMD_TURN_OFF_FALL_MS && lq.req.data == 16'h0000 |=>
    cq.inval && cq.tfall == $past(cq.tfall))
    else $error("zero fall time accepted");
  // Outside start-up no new timeout can race the clear
  a_clear_all: assert property (@(posedge clk_in) disable iff (rst_in)
    (cq.rq2 ^ cq.rq3) && lq.req.code == `PMTF_CMD_CLEAR && cq.st != ST_START |=>
    !cq.inval && !cq.badcmd && !cq.tonmax)
    else $error("clear-faults left a flag set");

endmodule // pmtf_top

// ### tb/pmtf_host.sv
`timescale 1ns/1ps
module pmtf_host (
  output logic             link_clk_out,
  output logic             wr_out,
  output logic             rd_out,
  output logic [7:0]       code_out,
  output logic [15:0]      wdata_out,
  input  wire logic        done_in,
  input  wire logic [15:0] rdata_in
);
  // ****************************************
  // Host side of the register link
  // ****************************************
  logic slow;
  initial begin
    link_clk_out = 1'b0;
    wr_out = 1'b0;
    rd_out = 1'b0;
    code_out = 8'h00;
    wdata_out = 16'h0000;
    slow = 1'b0;
    #2;
    forever begin
      link_clk_out = ~link_clk_out;
      #16;
    end
  end
  // One outstanding request; released strobes go low and code and data lines are inverted so stale data never looks valid
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] r, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    r = 16'h0000;
    repeat (slow ? 3 : 0) @(posedge link_clk_out);
    @(posedge link_clk_out);
    #1;
    wr_out = w;
    rd_out = ~w;
    code_out = c;
    wdata_out = d;
    @(posedge link_clk_out);
    #1;
    wr_out = 1'b0;
    rd_out = 1'b0;
    code_out = ~c;
    wdata_out = ~d;
    while (!ok && n < 40) begin
      if (done_in === 1'b1) begin
        ok = 1'b1;
        r = rdata_in;
      end else begin
        @(posedge link_clk_out);
        #1;
        n++;
      end
    end
  endtask
endmodule // pmtf_host

// ### tb/pmtf_top_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", n, (e), (g)); end end
module pmtf_top_bench import pmtf_pkg::*;;
  localparam int unsigned MSC = 10;
  logic        clk_in, rst_in, link_clk, wr, rd, op_on, done, alert_n, sw_on, vout_on, store, ok, busy;
  logic [7:0]  code, act;
  logic [15:0] wdata, rdata, r, dly, fall, e;
  logic [31:0] k;
  logic [39:0] image;
  logic [9:0]  ton_max;
  pmtf_pins_t  pins;
  int          fail_count, check_count, seed, stores, n;
  logic [23:0] cor [18] = '{24'h630080, 24'h6300F8, 24'h630000, 24'h630040, 24'h6300C0, 24'h630088,
    24'h630090, 24'h640000, 24'h64000A, 24'h64000B, 24'h640010, 24'h640800, 24'h650000, 24'h650001,
    24'h650014, 24'h650015, 24'h650020, 24'h650801};
  pmtf_top #(.MS_CYCLES(MSC)) pmtf_top_i (.clk_in(clk_in), .rst_in(rst_in), .link_clk_in(link_clk),
    .link_wr_in(wr), .link_rd_in(rd), .link_code_in(code), .link_wdata_in(wdata), .pins_in(pins),
    .op_on_in(op_on), .ton_max_ms_in(ton_max), .link_busy_out(busy), .link_done_out(done),
    .link_rdata_out(rdata), .host_alert_n_out(alert_n), .switching_on_out(sw_on),
    .vout_on_out(vout_on), .nvm_store_out(store), .nvm_image_out(image));
  pmtf_host pmtf_host_i (.link_clk_out(link_clk), .wr_out(wr), .rd_out(rd), .code_out(code),
    .wdata_out(wdata), .done_in(done), .rdata_in(rdata));
  // ****************************************
  // Expectations and helpers
  // ****************************************
  function automatic logic ok_act(input logic [15:0] d);
    return d[15:8] == 8'h00 && !d[6] && (d[5:3] == 3'h0 || d[5:3] == 3'h7) && d[2:0] == 3'h0;
  endfunction
  function automatic logic [15:0] exp_word(input pmtf_pins_t p, input logic comm_logic_fault_flag);
    logic v;
    v = |p.vendor[7:1];
    return {p.vout_ovp | p.vout_uv, p.ioc_peak | p.ioc_avg, p.vin_ov | p.vin_off, v, ~p.out_valid, 3'h0,
      p.nvm_busy, 1'b1, p.vout_ovp, p.ioc_peak, 1'b0, p.temp_flt, p.pec_err | comm_logic_fault_flag,
      p.vin_ov | p.vin_off | p.ioc_avg | p.sw_flt | p.boot_uv | p.pgood_flt | p.vout_uv | v};
  endfunction
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask
  task automatic set_run(input logic v);
    tick();
    op_on = v;
  endtask
  task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d);
    pmtf_host_i.xfer(w, c, d, r, ok);
    `CHK("answer", 1'b1, ok)
    `CHK("busy", 1'b0, busy)
  endtask
  task automatic wr_chk(input logic [7:0] c, input logic [15:0] d);
    logic good;
    good = c == 8'h63 ? ok_act(d) : c == 8'h64 ? d <= 16'h000A : d >= 16'h0001 && d <= 16'h0014;
    acc(1'b1, c, d);
    if (good && c == 8'h63) act = d[7:0];
    if (good && c == 8'h64) dly = d;
    if (good && c == 8'h65) fall = d;
    acc(1'b0, c, 16'h0000);
    `CHK("readback", c == 8'h63 ? {8'h00, act} : c == 8'h64 ? dly : fall, r)
    acc(1'b0, 8'h78, 16'h0000);
    `CHK("comm bit", ~good, r[1])
    `CHK("alert", good, alert_n)
    if (!good) acc(1'b1, 8'h03, 16'h0000);
  endtask
  // Bounded wait on switching (sel 0) or output command (sel 1)
  task automatic wait_out(input logic sel, input logic v, input int lim);
    n = 0;
    while ((sel ? vout_on : sw_on) !== v && n < lim) begin
      tick();
      n++;
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial clk_in = 1'b0;
  always #4 clk_in = ~clk_in;
  always @(posedge clk_in) if (store === 1'b1) stores <= stores + 1;
  initial begin
    #480000;
    fail_count++;
    wrap_up();
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_in = 1'b1;
    op_on = 1'b0;
    ton_max = 10'h005;
    pins = '0;
    seed = 97;
    fail_count = 0;
    check_count = 0;
    stores = 0;
    act = 8'h80;
    dly = 16'h0000;
    fall = 16'h0005;
    repeat (5) tick();
    rst_in = 1'b0;
    `CHK("image", 40'h8000000005, image)
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, 8'h63 + 8'(i), 16'h0000);
      `CHK("reset value", i == 0 ? 16'h0080 : i == 1 ? 16'h0000 : 16'h0005, r)
    end
    foreach (cor[j]) wr_chk(cor[j][23:16], cor[j][15:0]);
    for (int i = 0; i < 24; i++) begin
      k = $random(seed);
      pmtf_host_i.slow = k[12];
      if (k[1:0] == 2'h0) wr_chk(8'h63, {8'h00, k[15:8]});
      else wr_chk(k[1:0] == 2'h1 ? 8'h64 : 8'h65, k[3] ? {11'h000, k[8:4]} : k[31:16]);
    end
    acc(1'b0, 8'h9C, 16'h0000);
    acc(1'b0, 8'h79, 16'h0000);
    `CHK("bad command", exp_word(pins, 1'b1), r)
    acc(1'b1, 8'h03, 16'h0000);
    acc(1'b0, 8'h78, 16'h0000);
    `CHK("cleared byte", 16'h0040, r)
    acc(1'b1, 8'h15, 16'h0000);
    `CHK("store pulse", 1, stores)
    `CHK("store image", {act, dly, fall}, image)
    wr_chk(8'h63, 16'h0080);
    wr_chk(8'h64, 16'h0002);
    wr_chk(8'h65, 16'h0003);
    tick();
    pins.en_pin = 1'b1;
    pins.uv_reached = 1'b1;
    pins.out_valid = 1'b1;
    set_run(1'b1);
    wait_out(1'b1, 1'b1, 50);
    acc(1'b0, 8'h79, 16'h0000);
    `CHK("power good", 1'b0, r[11])
    set_run(1'b0);
    wait_out(1'b0, 1'b0, 300);
    `CHK("off delay", 1'b1, n >= 2 * MSC && n <= 2 * MSC + 6)
    wait_out(1'b1, 1'b0, 300);
    `CHK("fall time", 1'b1, n >= 3 * MSC - 2 && n <= 3 * MSC + 2)
    // Latch-off, then hiccup, then ignore; all start with the output never reaching UV
    for (int m = 0; m < 3; m++) begin
      wr_chk(8'h63, m == 0 ? 16'h0080 : m == 1 ? 16'h00B8 : 16'h0000);
      tick();
      pins.uv_reached = 1'b0;
      set_run(1'b1);
      wait_out(1'b0, 1'b1, 50);
      wait_out(1'b0, 1'b0, 100);
      `CHK("timeout alert", 1'b0, alert_n)
      if (m == 2) `CHK("ignore", 1'b1, sw_on)
      else `CHK("timeout span", 1'b1, n >= 5 * MSC - 3 && n <= 5 * MSC + 6)
      if (m == 0) begin
        tick();
        pins.uv_reached = 1'b1;
        wait_out(1'b0, 1'b1, 100);
        `CHK("latched", 1'b0, sw_on)
        acc(1'b0, 8'h79, 16'h0000);
        `CHK("vout summary", 1'b1, r[15])
      end
      if (m == 1) begin
        wait_out(1'b0, 1'b1, 10100);
        `CHK("hiccup", 1'b1, n >= 1000 * MSC - 5 && n <= 1000 * MSC + 5)
        wait_out(1'b0, 1'b0, 100);
        set_run(1'b0);
        wait_out(1'b0, 1'b1, 10100);
        `CHK("retry stop", 1'b0, sw_on)
      end
      acc(1'b1, 8'h03, 16'h0000);
      `CHK("alert clear", 1'b1, alert_n)
      set_run(1'b0);
      wait_out(1'b1, 1'b0, 300);
    end
    for (int i = 0; i < 12; i++) begin
      tick();
      pins = pmtf_pins_t'(23'($random(seed)));
      pins.en_pin = 1'b0;
      repeat (4) tick();
      e = exp_word(pins, 1'b0);
      acc(1'b0, 8'h79, 16'h0000);
      `CHK("status word", e, r)
      acc(1'b0, 8'h78, 16'h0000);
      `CHK("status byte", {8'h00, e[7:0]}, r)
    end
    wrap_up();
  end
endmodule // pmtf_top_bench
